/* File: src/aof_top.sv */
// Summary of operation
// - offset binary by default, twos complement selectable
// - offset binary: full scale ones, midscale leading one
// - four lanes, ten bits per sample
// - bit clock at five per frame, both edges
// - frame clock marks each new word
// - low rate setting halves the frame rate
// - test code drives all four lanes alike; one gives midscale
// - codes two and three: ones, zeros, formatted
// - code four: checkerboard alternating, unformatted
// - codes five, six: long, short pseudorandom
// - code seven: ones and zeros word toggle
// - code eight: alternate two user words
// - code nine: fixed alternating bit word
// - code ten: fixed sync word
// - code eleven: only first bit set
// - code twelve: fixed mixed frequency word
// - short sequence 511 bits, seed 0x0df
// - long sequence 8388607 bits, inverted, seeded
// - msb first by default, lsb first option
`timescale 1ns/1ps
`include "aof_defs.svh"

module aof_top (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire aof_pkg::aof_word_t adc_sample_0,
    input  wire aof_pkg::aof_word_t adc_sample_1,
    input  wire aof_pkg::aof_word_t adc_sample_2,
    input  wire aof_pkg::aof_word_t adc_sample_3,
    output logic                    sample_strobe,
    input  wire logic               spi_csb_n,
    input  wire logic               spi_sclk,
    input  wire logic               spi_sdio_in,
    output logic                    spi_sdio_out,
    output logic                    spi_sdio_oe,
    output logic                    lane_0,
    output logic                    lane_1,
    output logic                    lane_2,
    output logic                    lane_3,
    output logic                    bit_clock_out,
    output logic                    frame_clock_out,
    output logic                    reduced_swing_select
);
    import aof_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // twos complement view of an offset binary word
    function automatic aof_word_t twos_fmt(input aof_word_t w,
                                           input logic twos);
        return twos ? {~w[`AOF_WORD_W-1], w[`AOF_WORD_W-2:0]} : w;
    endfunction

    // bit order seen on the lane
    function automatic aof_word_t orient(input aof_word_t w,
                                         input logic lsb_first);
        aof_word_t r;
        r = w;
        if (lsb_first) begin
            for (int i = 0; i < `AOF_WORD_W; i++) begin
                r[i] = w[`AOF_WORD_W-1-i];
            end
        end
        return r;
    endfunction

    // word chosen for a frame
    function automatic aof_word_t pick_word(input aof_test_t tm,
                                            input aof_word_t smp,
                                            input logic odd,
                                            input aof_word_t u1,
                                            input aof_word_t u2,
                                            input aof_word_t pl,
                                            input aof_word_t ps,
                                            input logic twos);
        aof_word_t w;
        case (tm)
            tm_mid:    w = twos_fmt(`AOF_WORD_MID, twos);
            tm_pfs:    w = twos_fmt(`AOF_WORD_ONES, twos);
            tm_nfs:    w = twos_fmt(`AOF_WORD_ZEROS, twos);
            tm_check:  w = odd ? `AOF_WORD_CHECK_B : `AOF_WORD_CHECK_A;
            tm_long:   w = twos_fmt(pl, twos);
            tm_short:  w = twos_fmt(ps, twos);
            tm_toggle: w = odd ? `AOF_WORD_ZEROS : `AOF_WORD_ONES;
            tm_user:   w = odd ? u2 : u1;
            tm_bittog: w = `AOF_WORD_CHECK_A;
            tm_sync:   w = `AOF_WORD_SYNC;
            tm_onehi:  w = `AOF_WORD_MID;
            tm_mixed:  w = `AOF_WORD_MIXED;
            default:   w = twos_fmt(smp, twos);
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial port pin synchronisers

    logic [2:0] sync_meta;
    logic [2:0] sync_s;
    logic       sclk_d;
    logic [2:0] next_sync_meta;
    logic [2:0] next_sync_s;
    logic       next_sclk_d;
    logic       csb_s;
    logic       sclk_s;
    logic       sdio_s;
    logic       sclk_rise;
    logic       sclk_fall;

    // two flops per pin, edge detection on the second only
    always_comb begin
        next_sync_meta = {spi_csb_n, spi_sclk, spi_sdio_in};
        next_sync_s    = sync_meta;
        next_sclk_d    = sync_s[1];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_meta <= 3'h4;
            sync_s    <= 3'h4;
            sclk_d    <= 1'b0;
        end else begin
            sync_meta <= next_sync_meta;
            sync_s    <= next_sync_s;
            sclk_d    <= next_sclk_d;
        end
    end

    assign csb_s     = sync_s[2];
    assign sclk_s    = sync_s[1];
    assign sdio_s    = sync_s[0];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    ////////////////////////////////////////////////////////////////////////
    // serial port slave: 16 bit instruction, one data byte

    aof_spi_t              spi_state;
    logic [4:0]            spi_cnt;
    logic [15:0]           spi_sh;
    logic [`AOF_ADDR_W-1:0] spi_addr;
    logic                  spi_rd;
    logic [7:0]            spi_tx;
    aof_spi_t              next_spi_state;
    logic [4:0]            next_spi_cnt;
    logic [15:0]           next_spi_sh;
    logic [`AOF_ADDR_W-1:0] next_spi_addr;
    logic                  next_spi_rd;
    logic [7:0]            next_spi_tx;
    logic                  next_sdio_out;
    logic                  next_sdio_oe;
    logic                  wr_en;
    logic [7:0]            wr_data;
    logic [7:0]            rd_data;
    logic [`AOF_ADDR_W-1:0] cmd_addr;

    assign cmd_addr = {spi_sh[`AOF_ADDR_W-2:0], sdio_s};

    // frame the instruction, then shift the data byte in or out
    always_comb begin
        next_spi_state = spi_state;
        next_spi_cnt   = spi_cnt;
        next_spi_sh    = spi_sh;
        next_spi_addr  = spi_addr;
        next_spi_rd    = spi_rd;
        next_spi_tx    = spi_tx;
        next_sdio_out  = spi_sdio_out;
        next_sdio_oe   = spi_sdio_oe;
        wr_en          = 1'b0;
        wr_data        = {spi_sh[6:0], sdio_s};
        if (sclk_rise) begin
            next_spi_sh  = {spi_sh[14:0], sdio_s};
            next_spi_cnt = spi_cnt + 5'h01;
        end
        case (spi_state)
            spi_idle: begin
                next_spi_cnt = '0;
                next_sdio_oe = 1'b0;
                if (!csb_s) begin
                    next_spi_state = spi_cmd;
                end
            end
            spi_cmd: begin
                if (sclk_rise && spi_cnt == `AOF_SPI_CMD_LAST) begin
                    next_spi_rd    = spi_sh[14];
                    next_spi_addr  = cmd_addr;
                    next_spi_tx    = rd_data;
                    next_spi_state = spi_data;
                end
            end
            spi_data: begin
                if (sclk_fall && spi_rd) begin
                    next_sdio_out = spi_tx[7];
                    next_sdio_oe  = 1'b1;
                    next_spi_tx   = {spi_tx[6:0], 1'b0};
                end
                if (sclk_rise && spi_cnt == `AOF_SPI_DATA_LAST) begin
                    wr_en          = ~spi_rd;
                    next_spi_state = spi_done;
                end
            end
            spi_done: begin
                if (sclk_fall) begin
                    next_sdio_oe = 1'b0;
                end
            end
            default: next_spi_state = spi_idle;
        endcase
        if (csb_s) begin
            next_spi_state = spi_idle;
            next_sdio_oe   = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            spi_state    <= spi_idle;
            spi_cnt      <= '0;
            spi_sh       <= '0;
            spi_addr     <= '0;
            spi_rd       <= 1'b0;
            spi_tx       <= '0;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe  <= 1'b0;
        end else begin
            spi_state    <= next_spi_state;
            spi_cnt      <= next_spi_cnt;
            spi_sh       <= next_spi_sh;
            spi_addr     <= next_spi_addr;
            spi_rd       <= next_spi_rd;
            spi_tx       <= next_spi_tx;
            spi_sdio_out <= next_sdio_out;
            spi_sdio_oe  <= next_sdio_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    aof_test_t  test_mode;
    logic [7:0] out_mode;
    logic [7:0] user_reg [4];
    logic [7:0] frame_cnt;
    aof_test_t  next_test_mode;
    logic [7:0] next_out_mode;
    logic [7:0] next_user_reg [4];
    logic       tm_restart;

    // write decode; writing the test mode restarts the generators
    always_comb begin
        next_test_mode = test_mode;
        next_out_mode  = out_mode;
        next_user_reg  = user_reg;
        tm_restart     = 1'b0;
        if (wr_en) begin
            case (spi_addr)
                `AOF_REG_TEST_MODE: begin
                    next_test_mode = aof_test_t'(wr_data[3:0]);
                    tm_restart     = 1'b1;
                end
                `AOF_REG_OUT_MODE: next_out_mode    = wr_data;
                `AOF_REG_USER1_LO: next_user_reg[0] = wr_data;
                `AOF_REG_USER1_HI: next_user_reg[1] = wr_data;
                `AOF_REG_USER2_LO: next_user_reg[2] = wr_data;
                `AOF_REG_USER2_HI: next_user_reg[3] = wr_data;
                default: ;
            endcase
        end
    end

    // read decode for the instruction address
    always_comb begin
        case (cmd_addr)
            `AOF_REG_FRAME_CNT: rd_data = frame_cnt;
            `AOF_REG_TEST_MODE: rd_data = {4'h0, test_mode};
            `AOF_REG_OUT_MODE:  rd_data = out_mode;
            `AOF_REG_USER1_LO:  rd_data = user_reg[0];
            `AOF_REG_USER1_HI:  rd_data = user_reg[1];
            `AOF_REG_USER2_LO:  rd_data = user_reg[2];
            `AOF_REG_USER2_HI:  rd_data = user_reg[3];
            default:            rd_data = `AOF_READ_NONE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            test_mode <= tm_off;
            out_mode  <= `AOF_OUT_MODE_RST;
            user_reg  <= '{default: `AOF_USER_RST};
        end else begin
            test_mode <= next_test_mode;
            out_mode  <= next_out_mode;
            user_reg  <= next_user_reg;
        end
    end

    assign reduced_swing_select = out_mode[`AOF_BIT_SWING];

    ////////////////////////////////////////////////////////////////////////
    // bit slot and frame timing

    logic [2:0] div_cnt;
    logic [3:0] bit_cnt;
    logic       frame_odd;
    logic [2:0] next_div_cnt;
    logic [3:0] next_bit_cnt;
    logic       next_frame_odd;
    logic [7:0] next_frame_cnt;
    logic       next_bclk;
    logic       next_fclk;
    logic       next_strobe;
    logic [2:0] div_lim;
    logic       slot_en;
    logic       mid_en;
    logic       load;

    // low rate doubles the slot length
    assign div_lim = out_mode[`AOF_BIT_LOW_RATE] ? `AOF_SLOT_DIV_LOW
                                                 : `AOF_SLOT_DIV;
    assign slot_en = (div_cnt == 3'h0);
    assign mid_en  = (div_cnt == (div_lim >> 1));
    assign load    = slot_en && (bit_cnt == `AOF_LAST_BIT);

    always_comb begin
        next_div_cnt   = (div_cnt >= div_lim - 3'h1) ? 3'h0 : div_cnt + 3'h1;
        next_bit_cnt   = bit_cnt;
        next_frame_odd = frame_odd;
        next_frame_cnt = frame_cnt;
        next_bclk      = bit_clock_out;
        next_fclk      = frame_clock_out;
        next_strobe    = load;
        if (slot_en) begin
            next_bit_cnt = load ? 4'h0 : bit_cnt + 4'h1;
            next_fclk = (next_bit_cnt < `AOF_FRAME_HIGH);
        end
        if (load) begin
            next_frame_odd = ~frame_odd;
            next_frame_cnt = frame_cnt + 8'h01;
        end
        if (mid_en) begin
            next_bclk = ~bit_clock_out;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt         <= 3'h0;
            bit_cnt         <= `AOF_LAST_BIT;
            frame_odd       <= 1'b1;
            frame_cnt       <= 8'h00;
            bit_clock_out   <= 1'b0;
            frame_clock_out <= 1'b0;
            sample_strobe   <= 1'b0;
        end else begin
            div_cnt         <= next_div_cnt;
            bit_cnt         <= next_bit_cnt;
            frame_odd       <= next_frame_odd;
            frame_cnt       <= next_frame_cnt;
            bit_clock_out   <= next_bclk;
            frame_clock_out <= next_fclk;
            sample_strobe   <= next_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pseudorandom generators, stepped one slot before each load

    aof_word_t prbs_long;
    aof_word_t prbs_short;
    logic      prbs_adv;

    assign prbs_adv = slot_en && (bit_cnt == `AOF_PRBS_STEP_BIT);

    aof_prbs #(
        .W      (`AOF_LONG_W),
        .TAP    (`AOF_LONG_TAP),
        .SEED   (`AOF_LONG_SEED),
        .INVERT (1'b1)
    ) u_prbs_long (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (tm_restart),
        .advance (prbs_adv),
        .word    (prbs_long)
    );

    aof_prbs #(
        .W      (`AOF_SHORT_W),
        .TAP    (`AOF_SHORT_TAP),
        .SEED   (`AOF_SHORT_SEED),
        .INVERT (1'b0)
    ) u_prbs_short (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (tm_restart),
        .advance (prbs_adv),
        .word    (prbs_short)
    );

    ////////////////////////////////////////////////////////////////////////
    // lane serialisers

    aof_word_t lane_smp [`AOF_LANES];
    logic      lane_q   [`AOF_LANES];
    aof_word_t user1;
    aof_word_t user2;

    assign lane_smp[0] = adc_sample_0;
    assign lane_smp[1] = adc_sample_1;
    assign lane_smp[2] = adc_sample_2;
    assign lane_smp[3] = adc_sample_3;
    assign user1 = {user_reg[1], user_reg[0][7:6]};
    assign user2 = {user_reg[3], user_reg[2][7:6]};

    for (genvar i = 0; i < `AOF_LANES; i++) begin : g_lane
        aof_word_t sh;
        aof_word_t next_sh;
        logic      next_q;
        aof_word_t word;

        assign word = orient(pick_word(test_mode, lane_smp[i], ~frame_odd,
                                       user1, user2, prbs_long, prbs_short,
                                       out_mode[`AOF_BIT_TWOS]),
                             out_mode[`AOF_BIT_LSB_FIRST]);

        // one bit per slot, msb of shifter first
        always_comb begin
            next_sh = sh;
            next_q  = lane_q[i];
            if (load) begin
                next_q  = word[`AOF_WORD_W-1];
                next_sh = {word[`AOF_WORD_W-2:0], 1'b0};
            end else if (slot_en) begin
                next_q  = sh[`AOF_WORD_W-1];
                next_sh = {sh[`AOF_WORD_W-2:0], 1'b0};
            end
        end

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                sh        <= '0;
                lane_q[i] <= 1'b0;
            end else begin
                sh        <= next_sh;
                lane_q[i] <= next_q;
            end
        end
    end

    assign lane_0 = lane_q[0];
    assign lane_1 = lane_q[1];
    assign lane_2 = lane_q[2];
    assign lane_3 = lane_q[3];

endmodule

/* File: src/aof_defs.svh */
`ifndef AOF_DEFS_SVH
`define AOF_DEFS_SVH

// word and lane geometry
`define AOF_WORD_W          10
`define AOF_LANES           4
`define AOF_LAST_BIT        4'h9
`define AOF_PRBS_STEP_BIT   4'h8
`define AOF_FRAME_HIGH      4'h5

// sample rate figures, the bit slot divider and the low rate divider derived from them
`define AOF_RATE_MIN_MSPS   10
`define AOF_RATE_LOW_MSPS   5
`define AOF_SLOT_DIV        3'h2
`define AOF_SLOT_DIV_LOW    3'(`AOF_SLOT_DIV * `AOF_RATE_MIN_MSPS / `AOF_RATE_LOW_MSPS)

// serial port framing
`define AOF_ADDR_W          13
`define AOF_SPI_CMD_LAST    5'h0f
`define AOF_SPI_DATA_LAST   5'h17

// register addresses
`define AOF_REG_FRAME_CNT   13'h002
`define AOF_REG_TEST_MODE   13'h00d
`define AOF_REG_OUT_MODE    13'h014
`define AOF_REG_USER1_LO    13'h019
`define AOF_REG_USER1_HI    13'h01a
`define AOF_REG_USER2_LO    13'h01b
`define AOF_REG_USER2_HI    13'h01c

// output mode fields and reset values
`define AOF_BIT_TWOS        0
`define AOF_BIT_SWING       1
`define AOF_BIT_LSB_FIRST   2
`define AOF_BIT_LOW_RATE    3
`define AOF_OUT_MODE_RST    8'h00
`define AOF_USER_RST        8'h00
`define AOF_READ_NONE       8'h00

// fixed pattern words
`define AOF_WORD_MID        10'h200
`define AOF_WORD_ONES       10'h3ff
`define AOF_WORD_ZEROS      10'h000
`define AOF_WORD_CHECK_A    10'h2aa
`define AOF_WORD_CHECK_B    10'h155
`define AOF_WORD_SYNC       10'h01f
`define AOF_WORD_MIXED      10'h263

// pseudorandom generators
`define AOF_SHORT_W         9
`define AOF_SHORT_TAP       5
`define AOF_SHORT_SEED      23'h0000df
`define AOF_LONG_W          23
`define AOF_LONG_TAP        18
`define AOF_LONG_SEED       23'h0a6e02

`endif

/* File: src/aof_pkg.sv */
`include "aof_defs.svh"

package aof_pkg;

    typedef logic [`AOF_WORD_W-1:0] aof_word_t;

    typedef enum logic [3:0] {
        tm_off    = 4'h0,
        tm_mid    = 4'h1,
        tm_pfs    = 4'h2,
        tm_nfs    = 4'h3,
        tm_check  = 4'h4,
        tm_long   = 4'h5,
        tm_short  = 4'h6,
        tm_toggle = 4'h7,
        tm_user   = 4'h8,
        tm_bittog = 4'h9,
        tm_sync   = 4'ha,
        tm_onehi  = 4'hb,
        tm_mixed  = 4'hc
    } aof_test_t;

    typedef enum logic [3:0] {
        spi_idle = 4'b0001,
        spi_cmd  = 4'b0010,
        spi_data = 4'b0100,
        spi_done = 4'b1000
    } aof_spi_t;

endpackage

/* File: src/aof_prbs.sv */
`timescale 1ns/1ps
`include "aof_defs.svh"

module aof_prbs #(
    parameter int          W      = `AOF_SHORT_W,
    parameter int          TAP    = `AOF_SHORT_TAP,
    parameter logic [22:0] SEED   = `AOF_SHORT_SEED,
    parameter bit          INVERT = 1'b0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             restart,
    input  wire logic             advance,
    output aof_pkg::aof_word_t    word
);
    import aof_pkg::*;

    logic [W-1:0] state;
    logic [W-1:0] next_state;
    aof_word_t    next_word;

    // run the generator one whole word ahead, first bit into the msb
    always_comb begin
        logic [W-1:0] s;
        logic         fb;
        aof_word_t    w;
        s  = restart ? SEED[W-1:0] : state;
        fb = 1'b0;
        w  = '0;
        for (int i = 0; i < `AOF_WORD_W; i++) begin
            fb = s[W-1] ^ s[TAP-1];
            w[`AOF_WORD_W-1-i] = fb ^ INVERT;
            s = {s[W-2:0], fb};
        end
        next_state = restart ? SEED[W-1:0] : state;
        next_word  = word;
        if (advance) begin
            next_state = s;
            next_word  = w;
        end
    end

    // generator state and the word it last produced
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SEED[W-1:0];
            word  <= '0;
        end else begin
            state <= next_state;
            word  <= next_word;
        end
    end

endmodule

/* File: sim/aof_top_props.sv */
`timescale 1ns/1ps
module aof_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_strobe,
    input wire logic lane_0,
    input wire logic bit_clock_out,
    input wire logic frame_clock_out
);
    logic [3:0] tg;
    logic [3:0] next_tg;
    logic       fq;
    logic       bq;
    logic       seen;
    logic       next_seen;

    // bit clock toggles since the latest frame start
    always_comb begin
        next_seen = seen | (frame_clock_out & ~fq);
        next_tg = tg + 4'(bit_clock_out ^ bq);
        if (frame_clock_out & ~fq) begin
            next_tg = 4'h0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tg <= 4'h0;
            fq <= 1'b0;
            bq <= 1'b0;
            seen <= 1'b0;
        end else begin
            tg <= next_tg;
            fq <= frame_clock_out;
            bq <= bit_clock_out;
            seen <= next_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_hi;
        frame_clock_out [*8];
    endsequence
    sequence s_lo;
        !frame_clock_out [*8];
    endsequence
    sequence s_gap;
        $stable(bit_clock_out) ##[1:4] $changed(bit_clock_out);
    endsequence

    a_fclk_high_half: assert property (
        $rose(frame_clock_out) |-> s_hi) else $error("frame high too short");
    a_fclk_low_half: assert property (
        $fell(frame_clock_out) |-> s_lo) else $error("frame low too short");
    a_frame_ten_toggles: assert property (
        $rose(frame_clock_out) && seen |-> tg == 4'ha)
        else $error("bit clock toggles per frame wrong");
    a_high_five_toggles: assert property (
        $fell(frame_clock_out) |-> tg == 4'h5)
        else $error("frame high not five slots");
    a_strobe_follows: assert property (
        $rose(frame_clock_out) |-> sample_strobe) else $error("no strobe");
    a_strobe_single: assert property (
        sample_strobe |=> !sample_strobe) else $error("strobe too long");
    a_strobe_cause: assert property (
        sample_strobe |-> $rose(frame_clock_out))
        else $error("strobe without frame start");
    a_lane_mid_stable: assert property (
        !$stable(lane_0) |-> $stable(bit_clock_out))
        else $error("lane moved on a bit clock edge");
    a_bclk_spacing: assert property (
        $changed(bit_clock_out) |=> s_gap) else $error("bit clock spacing");
endmodule

bind aof_top aof_props aof_props_u (.clk(clk), .sys_rst(sys_rst),
    .sample_strobe(sample_strobe), .lane_0(lane_0),
    .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out));

/* File: sim/aof_rx.sv */
`timescale 1ns/1ps
module aof_rx (
    input  wire logic         bclk,
    input  wire logic         fclk,
    input  wire logic [3:0]   lanes,
    output aof_pkg::aof_word_t word [4],
    output int                cnt
);
    import aof_pkg::*;
    aof_word_t  sh [4];
    logic [9:0] fs = 10'h000;

    initial cnt = 0;
    always @(bclk) begin
        fs = {fs[8:0], fclk};
        for (int i = 0; i < 4; i++) sh[i] = {sh[i][8:0], lanes[i]};
        if (fs == 10'h3e0) begin
            word = sh;
            cnt++;
        end
    end
endmodule

/* File: sim/tb_aof_top.sv */
`timescale 1ns/1ps
module tb_aof_top;
    import aof_pkg::*;
    logic      clk = 0;
    logic      sys_rst = 1;
    logic      csb_n = 1;
    logic      sclk = 0;
    logic      host_d = 0;
    aof_word_t smp [4] = '{default: 10'h3ff};
    aof_word_t rxw [4];
    logic      l0, l1, l2, l3, bclk, fclk, sdo, oe, rs;
    wire       sdio = oe ? sdo : host_d;
    int        rxc, cyc, error_cnt, num_checks, n;
    int        seed = 25;

    always #50 clk = ~clk;
    aof_top dut_u (.clk(clk), .sys_rst(sys_rst), .adc_sample_0(smp[0]),
        .adc_sample_1(smp[1]), .adc_sample_2(smp[2]), .adc_sample_3(smp[3]),
        .sample_strobe(), .spi_csb_n(csb_n), .spi_sclk(sclk),
        .spi_sdio_in(sdio), .spi_sdio_out(sdo), .spi_sdio_oe(oe),
        .lane_0(l0), .lane_1(l1), .lane_2(l2), .lane_3(l3),
        .bit_clock_out(bclk), .frame_clock_out(fclk),
        .reduced_swing_select(rs));
    aof_rx rx_u (.bclk(bclk), .fclk(fclk), .lanes({l3, l2, l1, l0}),
        .word(rxw), .cnt(rxc));

    ////////////////////////////////////////////////////////////////////////
    // expected word: msb flip for twos, bit reversal for lsb first
    function automatic aof_word_t fmt(aof_word_t w, logic t, logic l);
        aof_word_t r;
        r = w ^ {t, 9'h000};
        return l ? {<<{r}} : r;
    endfunction
    function automatic aof_word_t fixw(logic [3:0] m);
        case (m)
            4'h1, 4'hb: return 10'h200;
            4'h2: return 10'h3ff;
            4'h3: return 10'h000;
            4'h9: return 10'h2aa;
            4'ha: return 10'h01f;
            default: return 10'h263;
        endcase
    endfunction
    task automatic check(logic [9:0] seen, logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one serial port transfer, 800 ns serial clock
    task automatic spi(logic rd, logic [12:0] a, logic [7:0] d,
                       output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 2'b00, a, d};
        @(negedge clk) csb_n = 0;
        for (int i = 23; i >= 0; i--) begin
            host_d = f[i];
            repeat (4) @(negedge clk);
            sclk = 1;
            if (i < 8) q[i] = sdio;
            repeat (4) @(negedge clk);
            sclk = 0;
        end
        csb_n = 1;
        host_d = ~host_d;
        repeat (4) @(negedge clk);
    endtask
    task automatic cfg(logic [7:0] om, logic [3:0] m);
        logic [7:0] q;
        spi(0, 13'h014, om, q);
        spi(0, 13'h00d, {4'h0, m}, q);
        repeat (3) @(rxc);
        @(negedge clk);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] q;
        logic [7:0] u [4];
        logic       t, l;
        aof_word_t  a, w1, w2;
        logic [3:0] fm [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc};
        repeat (2) @(posedge clk);
        @(negedge clk) sys_rst = 0;
        // reset values and one unmapped address
        for (int r = 8'h19; r <= 8'h1d; r++) begin
            spi(1, 13'(r), 8'hff, q);
            check({2'b00, q}, 10'h000);
        end
        check(rxw[0], 10'h3ff);
        // converter data: corners, then random format and order
        for (int k = 0; k < 8; k++) begin
            t = (k > 2) ? 1'($random(seed)) : 1'b0;
            l = (k > 2) ? 1'($random(seed)) : 1'b0;
            @(negedge clk);
            foreach (smp[i]) smp[i] = 10'($random(seed));
            if (k < 3) smp[0] = (k == 0) ? 10'h3ff : (k == 1) ? 10'h200 : '0;
            cfg({5'h00, l, 1'b0, t}, 4'h0);
            foreach (rxw[i]) check(rxw[i], fmt(smp[i], t, l));
        end
        // fixed patterns with random format and order
        foreach (fm[j]) begin
            t = 1'($random(seed));
            l = 1'($random(seed));
            cfg({5'h00, l, t, t}, fm[j]);
            check(rxw[2], fmt(fixw(fm[j]), t & (fm[j] < 4), l));
            check({9'h000, rs}, {9'h000, t});
        end
        // alternating patterns, user words included
        foreach (u[i]) begin
            u[i] = 8'($random(seed));
            spi(0, 13'h019 + 13'(i), u[i], q);
        end
        for (int j = 0; j < 3; j++) begin
            w1 = j == 0 ? 10'h2aa : j == 1 ? 10'h3ff : {u[1], u[0][7:6]};
            w2 = j == 0 ? 10'h155 : j == 1 ? 10'h000 : {u[3], u[2][7:6]};
            cfg({7'h00, 1'($random(seed))},
                j == 0 ? 4'h4 : j == 1 ? 4'h7 : 4'h8);
            a = rxw[1];
            @(rxc);
            n = ({a, rxw[1]} === {w1, w2}) || ({a, rxw[1]} === {w2, w1});
            check(10'(n), 10'h001);
        end
        // pseudorandom patterns
        cfg(8'h00, 4'h6);
        a = rxw[0];
        repeat (511) @(rxc);
        check(rxw[0], a);
        cfg(8'h00, 4'h5);
        a = rxw[0];
        @(rxc);
        check({9'h000, a !== rxw[0]}, 10'h001);
        // low rate doubles the frame period
        cfg(8'h08, 4'h0);
        @(posedge fclk);
        n = cyc;
        @(posedge fclk);
        check(10'(cyc - n), 10'h028);
        spi(1, 13'h014, 8'h00, q);
        check({2'b00, q}, 10'h008);
        end_of_test();
    end
endmodule
